// ---- hdl/cbs_branch_unit.v ----
// conditional branch and io bit skip unit with apb register access
//
// Summary of operation
// - branch_on_flag_set jumps to pc+k+1 when selected flag is one, 1 or 2 cycles.
// - branch_on_flag_cleared jumps when selected flag is zero, else continues in sequence.
// - branch_if_equal jumps only while zero flag is 1.
// - branch_if_not_equal jumps only while zero flag is 0.
// - branch_if_carry_one and branch_if_lower jump only while carry is 1.
// - branch_if_carry_zero and branch_if_same_or_higher jump only while carry is 0.
// - branch_if_minus jumps only while negative flag is 1.
// - branch_if_plus jumps only while negative flag is 0.
// - branch_if_signed_ge jumps only when n xor v is 0.
// - branch_if_signed_lt jumps only when n xor v is 1.
// - branch_if_half_carry_one jumps only while half carry is 1.
// - branch_if_half_carry_zero jumps only while half carry is 0.
// - transfer bit set branch jumps only while transfer flag is 1.
// - skip_if_io_bit_one tests io bit b; when one pc advances 2 or 3.
// - no branch alters any status flag; branches take 1 or 2 cycles.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cbs_consts.vh"
module cbs_branch_unit #(
  parameter PC_W = 16,
  parameter K_W = 7
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // core side view
  output reg [PC_W-1:0] pc_out,
  output reg busy_out,
  output reg taken_out
);
  localparam ST_IDLE = 2'd0;
  localparam ST_EXEC = 2'd1;
  localparam ST_WAIT = 2'd2;

  // registers
  reg [1:0] state_r, state_nxt;
  reg [PC_W-1:0] pc_r, pc_nxt;
  reg [7:0] flags_r;
  reg [7:0] io_r;
  reg [4:0] op_r;
  reg [K_W-1:0] k_r;
  reg [2:0] sel_r;
  reg two_word_r;
  reg taken_r, taken_nxt;
  reg [1:0] wait_r, wait_nxt;
  reg [1:0] cyc_r, cyc_nxt;
  // combinational nets
  wire cond;
  wire acc;
  wire wr;
  wire bad_addr;
  wire go;
  wire is_skip;
  wire [PC_W-1:0] k_ext;
  wire [PC_W-1:0] seq_pc;
  wire [PC_W-1:0] skip_pc;
  wire [PC_W-1:0] jump_pc;
  wire [1:0] skip_wait;
  wire busy;
  reg rd_ok;
  reg [31:0] rdata_nxt;

  function addr_hit;
    input [11:0] a;
    input [11:0] reg_addr;
    begin
      addr_hit = (a == reg_addr);
    end
  endfunction

  // pc plus a small unsigned step, sized to the pc
  function [PC_W-1:0] pc_plus;
    input [PC_W-1:0] p;
    input [1:0] step;
    begin
      pc_plus = p + {{(PC_W-2){1'b0}}, step};
    end
  endfunction

  // codes above the skip are unassigned and run as a plain step
  function op_known;
    input [4:0] o;
    begin
      op_known = (o <= `CBS_OP_SKIP_IO);
    end
  endfunction

  // go reads back as zero; only the operand fields are visible
  function [31:0] ctrl_word;
    input [4:0] o;
    input [K_W-1:0] kk;
    input [2:0] s;
    input tw;
    begin
      ctrl_word = 32'h0000_0000;
      ctrl_word[`CBS_CTRL_OP_LSB +: 5] = o;
      ctrl_word[`CBS_CTRL_K_LSB +: K_W] = kk;
      ctrl_word[`CBS_CTRL_SEL_LSB +: 3] = s;
      ctrl_word[`CBS_CTRL_TWO_WORD_BIT] = tw;
    end
  endfunction

  // busy and taken sit just above the flag byte, the cycle count higher up
  function [31:0] status_word;
    input [1:0] cyc;
    input tkn;
    input bsy;
    input [7:0] fl;
    begin
      status_word = 32'h0000_0000;
      status_word[`CBS_STAT_FLAGS_LSB +: 8] = fl;
      status_word[`CBS_STAT_BUSY_BIT] = bsy;
      status_word[`CBS_STAT_TAKEN_BIT] = tkn;
      status_word[`CBS_STAT_CYC_LSB +: 2] = cyc;
    end
  endfunction

  cbs_cond_eval u_eval (
    .op(op_r),
    .sel(sel_r),
    .flags(flags_r),
    .io_byte(io_r),
    .cond(cond)
  );

  // one wait state per access: pready rises the cycle after penable, for one cycle
  assign acc = psel & penable & ~pready;
  assign wr = acc & pwrite;
  assign bad_addr = (paddr >= `CBS_ADDR_LAST) | (paddr[1:0] != 2'b00);
  // a new operation written while busy is dropped, keeping decode order intact
  assign go = wr & addr_hit(paddr, `CBS_ADDR_CTRL) & pwdata[`CBS_CTRL_GO_BIT]
    & (state_r == ST_IDLE);
  assign is_skip = (op_r == `CBS_OP_SKIP_IO);
  assign k_ext = {{(PC_W-K_W){k_r[K_W-1]}}, k_r};
  // every candidate target is formed each cycle; the state machine only picks one
  assign seq_pc = pc_plus(pc_r, 2'd1);
  assign skip_pc = pc_plus(pc_r, two_word_r ? 2'd3 : 2'd2);
  assign jump_pc = pc_r + k_ext + {{(PC_W-1){1'b0}}, 1'b1};
  assign skip_wait = two_word_r ? 2'd2 : 2'd1;
  assign busy = (state_r != ST_IDLE);

  // next-state logic; one operation is in flight at a time
  always @* begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    taken_nxt = taken_r;
    wait_nxt = wait_r;
    cyc_nxt = cyc_r;
    case (state_r)
      ST_IDLE: begin
        if (go) begin
          state_nxt = ST_EXEC;
          cyc_nxt = 2'd1;
          taken_nxt = 1'b0;
        end
      end
      ST_EXEC: begin
        taken_nxt = cond;
        if (op_r == `CBS_OP_NONE || !op_known(op_r)) begin
          pc_nxt = seq_pc;
          state_nxt = ST_IDLE;
        end else if (is_skip) begin
          if (cond) begin
            pc_nxt = skip_pc;
            wait_nxt = skip_wait;
            state_nxt = ST_WAIT;
          end else begin
            pc_nxt = seq_pc;
            state_nxt = ST_IDLE;
          end
        end else if (cond) begin
          // taken: target now, one refetch cycle follows
          pc_nxt = jump_pc;
          wait_nxt = 2'd1;
          state_nxt = ST_WAIT;
        end else begin
          // untaken: next instruction, single cycle
          pc_nxt = seq_pc;
          state_nxt = ST_IDLE;
        end
      end
      ST_WAIT: begin
        // refetch slots: the pc already holds its target, only time passes
        cyc_nxt = cyc_r + 2'd1;
        wait_nxt = wait_r - 2'd1;
        if (wait_r == 2'd1) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      pc_r <= `CBS_PC_RESET;
      taken_r <= 1'b0;
      wait_r <= 2'd0;
      cyc_r <= 2'd0;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      taken_r <= taken_nxt;
      wait_r <= wait_nxt;
      cyc_r <= cyc_nxt;
    end
  end

  // operands are latched only on an accepted go, so a refused write leaves them intact
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r <= `CBS_OP_NONE;
      k_r <= {K_W{1'b0}};
      sel_r <= 3'd0;
      two_word_r <= 1'b0;
    end else if (go) begin
      op_r <= pwdata[`CBS_CTRL_OP_LSB +: 5];
      k_r <= pwdata[`CBS_CTRL_K_LSB +: K_W];
      sel_r <= pwdata[`CBS_CTRL_SEL_LSB +: 3];
      two_word_r <= pwdata[`CBS_CTRL_TWO_WORD_BIT];
    end
  end

  // only software writes the flags; no branch or skip touches them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= `CBS_FLAGS_RESET;
      io_r <= 8'h00;
    end else begin
      if (wr & addr_hit(paddr, `CBS_ADDR_STATUS)) begin
        flags_r <= pwdata[7:0];
      end
      if (wr & addr_hit(paddr, `CBS_ADDR_IO)) begin
        io_r <= pwdata[7:0];
      end
    end
  end

  // read mux kept apart from the flops so the answer is decided in one place
  always @* begin
    rd_ok = acc & ~pwrite & ~bad_addr;
    rdata_nxt = 32'h0000_0000;
    if (rd_ok) begin
      case (paddr)
        `CBS_ADDR_CTRL: rdata_nxt = ctrl_word(op_r, k_r, sel_r, two_word_r);
        `CBS_ADDR_STATUS: rdata_nxt = status_word(cyc_r, taken_r, busy, flags_r);
        `CBS_ADDR_PC: rdata_nxt = {{(32-PC_W){1'b0}}, pc_r};
        `CBS_ADDR_IO: rdata_nxt = {24'h000000, io_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // the pc is read only over the bus, so a running branch can never be torn
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      pslverr <= acc & bad_addr;
      prdata <= rdata_nxt;
    end
  end

  // core-side copies come from flops so the core never sees decode glitches
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_out <= `CBS_PC_RESET;
      busy_out <= 1'b0;
      taken_out <= 1'b0;
    end else begin
      pc_out <= pc_nxt;
      busy_out <= (state_nxt != ST_IDLE);
      taken_out <= taken_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/cbs_cond_eval.v ----
// condition evaluation for branches and the io bit skip
`timescale 1ns/100ps
`default_nettype none
`include "cbs_consts.vh"
module cbs_cond_eval (
  // decoded operation
  input wire [4:0] op,
  input wire [2:0] sel,
  // state to test
  input wire [7:0] flags,
  input wire [7:0] io_byte,
  // result
  output reg cond
);
  always @* begin
    case (op)
      `CBS_OP_FLAG_SET: cond = flags[sel];
      `CBS_OP_FLAG_CLR: cond = ~flags[sel];
      `CBS_OP_EQ: cond = flags[`CBS_FLAG_Z];
      `CBS_OP_NE: cond = ~flags[`CBS_FLAG_Z];
      `CBS_OP_CARRY_ONE, `CBS_OP_LOWER: cond = flags[`CBS_FLAG_C];
      `CBS_OP_CARRY_ZERO, `CBS_OP_SAME_HIGHER: cond = ~flags[`CBS_FLAG_C];
      `CBS_OP_MINUS: cond = flags[`CBS_FLAG_N];
      `CBS_OP_PLUS: cond = ~flags[`CBS_FLAG_N];
      `CBS_OP_SIGNED_GE: cond = ~(flags[`CBS_FLAG_N] ^ flags[`CBS_FLAG_V]);
      `CBS_OP_SIGNED_LT: cond = flags[`CBS_FLAG_N] ^ flags[`CBS_FLAG_V];
      `CBS_OP_HALF_ONE: cond = flags[`CBS_FLAG_H];
      `CBS_OP_HALF_ZERO: cond = ~flags[`CBS_FLAG_H];
      `CBS_OP_T_ONE: cond = flags[`CBS_FLAG_T];
      `CBS_OP_T_ZERO: cond = ~flags[`CBS_FLAG_T];
      `CBS_OP_SKIP_IO: cond = io_byte[sel];
      default: cond = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ---- pkg/cbs_consts.vh ----
// constants for the conditional branch and skip unit
`ifndef CBS_CONSTS_VH
`define CBS_CONSTS_VH
// status flag bit positions
`define CBS_FLAG_C 3'd0
`define CBS_FLAG_Z 3'd1
`define CBS_FLAG_N 3'd2
`define CBS_FLAG_V 3'd3
`define CBS_FLAG_S 3'd4
`define CBS_FLAG_H 3'd5
`define CBS_FLAG_T 3'd6
`define CBS_FLAG_I 3'd7
// operation codes on op
`define CBS_OP_NONE 5'h00
`define CBS_OP_FLAG_SET 5'h01
`define CBS_OP_FLAG_CLR 5'h02
`define CBS_OP_EQ 5'h03
`define CBS_OP_NE 5'h04
`define CBS_OP_CARRY_ONE 5'h05
`define CBS_OP_CARRY_ZERO 5'h06
`define CBS_OP_SAME_HIGHER 5'h07
`define CBS_OP_LOWER 5'h08
`define CBS_OP_MINUS 5'h09
`define CBS_OP_PLUS 5'h0a
`define CBS_OP_SIGNED_GE 5'h0b
`define CBS_OP_SIGNED_LT 5'h0c
`define CBS_OP_HALF_ONE 5'h0d
`define CBS_OP_HALF_ZERO 5'h0e
`define CBS_OP_T_ONE 5'h0f
`define CBS_OP_T_ZERO 5'h10
`define CBS_OP_SKIP_IO 5'h11
// apb register byte addresses
`define CBS_ADDR_CTRL 12'h000
`define CBS_ADDR_STATUS 12'h004
`define CBS_ADDR_PC 12'h008
`define CBS_ADDR_IO 12'h00c
`define CBS_ADDR_LAST 12'h010
// ctrl fields
`define CBS_CTRL_OP_LSB 0
`define CBS_CTRL_K_LSB 8
`define CBS_CTRL_SEL_LSB 16
`define CBS_CTRL_TWO_WORD_BIT 20
`define CBS_CTRL_GO_BIT 31
// status read fields
`define CBS_STAT_FLAGS_LSB 0
`define CBS_STAT_BUSY_BIT 8
`define CBS_STAT_TAKEN_BIT 9
`define CBS_STAT_CYC_LSB 12
// reset values
`define CBS_PC_RESET 16'h0000
`define CBS_FLAGS_RESET 8'h00
`endif

// ---- tb/cbs_branch_unit_tb.sv ----
// self-checking bench for the branch and skip unit
`timescale 1ns/100ps
`default_nettype none
module cbs_branch_unit_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic busy_out, taken_out, er, tk;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] pc_out, pc_exp;
  logic [7:0] f;
  logic [7:0] pat [4] = '{8'h00, 8'hff, 8'h04, 8'h6b};
  logic [6:0] k;
  logic [4:0] op;
  logic [1:0] cy;
  int error_cnt = 0, checked = 0;
  always #2.5 pclk = ~pclk;
  cbs_branch_unit #(.PC_W(16), .K_W(7)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pc_out(pc_out), .busy_out(busy_out),
    .taken_out(taken_out));
  task automatic summarize;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // holds the request until pready is seen, releases it on that edge and idles one more
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic cond(input logic [4:0] o, input logic [2:0] s,
    input logic [7:0] fl, input logic [7:0] io);
    logic c, z, n, v, h, t;
    logic [16:0] tv;
    {t, h, v, n, z, c} = {fl[6], fl[5], fl[3:0]};
    tv = {io[s], !t, t, !h, h, n ^ v, !(n ^ v), !n, n, c, !c, !c, c, !z, z, !fl[s], fl[s]};
    return tv[o - 5'h01];
  endfunction
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    pc_exp = 16'h0;
    // every op except op none against four flag patterns; k alternates between both signed extremes
    for (int i = 0; i < 68; i++) begin
      op = 5'(i % 17 + 1);
      f = pat[i / 17];
      k = i[0] ? 7'h40 : 7'h3f;
      tk = cond(op, i[2:0], f, ~f);
      apb(1'b1, 12'h004, {24'h0, f});
      apb(1'b1, 12'h00c, {24'h0, ~f});
      apb(1'b1, 12'h000, {1'b1, 10'h0, i[1], 1'b0, i[2:0], 1'b0, k, 3'h0, op});
      for (int n = 0; busy_out !== 1'b0 && n < 20; n++) @(posedge pclk);
      cy = !tk ? 2'd1 : (op == 5'h11) ? 2'd2 + 2'(i[1]) : 2'd2;
      pc_exp += !tk ? 16'h1 : (op == 5'h11) ? 16'h2 + 16'(i[1]) : {{9{k[6]}}, k} + 16'h1;
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, {16'h0, pc_exp});
      chk({busy_out, taken_out, pc_out}, {1'b0, tk, pc_exp});
      apb(1'b0, 12'h004, 32'h0);
      chk({rd[13:12], rd[9:0]}, {cy, tk, 1'b0, f});
    end
    // op none steps the pc once; the operand fields read back without go
    apb(1'b1, 12'h000, {1'b1, 10'h0, 1'b1, 1'b0, 3'd5, 1'b0, 7'h2a, 3'h0, 5'h00});
    pc_exp += 16'h1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, {11'h0, 1'b1, 1'b0, 3'd5, 1'b0, 7'h2a, 3'h0, 5'h00});
    apb(1'b0, 12'h004, 32'h0);
    chk({rd[13:12], rd[9:0]}, {2'd1, 1'b0, 1'b0, 8'h6b});
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, {24'h0, 8'h94});
    // the pc is read only over the bus
    apb(1'b1, 12'h008, 32'h1234);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, {16'h0, pc_exp});
    chk(pc_out, pc_exp);
    apb(1'b0, 12'h010, 32'h0);
    chk(32'(er), 32'h1);
    summarize;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    summarize;
  end
endmodule
bind cbs_branch_unit cbs_unit_checker #(.PC_W(16), .K_W(7)) chk_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pc_out(pc_out), .busy_out(busy_out),
  .taken_out(taken_out));
`default_nettype wire

// ---- tb/cbs_unit_checker.sv ----
// port assertions for the branch and skip unit
`timescale 1ns/100ps
`default_nettype none
module cbs_unit_checker #(
  parameter PC_W = 16,
  parameter K_W = 7
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // core view
  input wire logic [PC_W-1:0] pc_out,
  input wire logic busy_out,
  input wire logic taken_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  ready_latency_a: assert property (psel && $rose(penable) |=> pready)
    else $error("pready not one cycle after access start");
  bad_addr_err_a: assert property (psel && $rose(penable) && (paddr >= 12'h010 ||
    paddr[1:0] != 2'b00) |=> pslverr) else $error("bad address not refused");
  good_addr_ok_a: assert property (psel && $rose(penable) && paddr < 12'h010 &&
    paddr[1:0] == 2'b00 |=> !pslverr) else $error("good address refused");
  idle_rdata_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside answer");
  pc_hold_a: assert property (!busy_out && !$past(busy_out) |-> $stable(pc_out))
    else $error("pc moved while idle");
  busy_span_a: assert property ($rose(busy_out) |-> ##[1:3] !busy_out)
    else $error("operation longer than three cycles");
  untaken_short_a: assert property ($fell(busy_out) && !taken_out |->
    !$past(busy_out, 2)) else $error("untaken operation longer than one cycle");
  taken_long_a: assert property ($fell(busy_out) && taken_out |->
    $past(busy_out, 2)) else $error("taken operation shorter than two cycles");
  cover property ($rose(busy_out) ##3 $fell(busy_out));
  cover property ($fell(busy_out) && taken_out);
  cover property ($fell(busy_out) && !taken_out);
  cover property (pslverr);
endmodule
`default_nettype wire
